// File: omc_ctrl.sv
// Control pin sequencing, fault latch, rate select and monitor calibration
module omc_ctrl import omc_pkg::*; #(
  parameter bit COOLED = 1'b0,
  parameter longint unsigned MGMT_INIT_CYC = OMC_MGMT_INIT_CYC,
  parameter longint unsigned START_CYC = OMC_START_CYC,
  parameter longint unsigned START_COOLED_CYC = OMC_START_COOLED_CYC,
  parameter longint unsigned HP_ENTRY_CYC = OMC_HP_ENTRY_CYC,
  parameter longint unsigned RATE_FC_CYC = OMC_RATE_FC_CYC,
  parameter longint unsigned RATE_CYC = OMC_RATE_CYC,
  parameter logic [6:0] DEV_ADDR = OMC_DEV_ADDR,
  parameter omc_mon_s CAL_SLOPE = {5{OMC_SLOPE_ONE}},
  parameter omc_mon_s CAL_OFFS = {5{OMC_OFFS_ZERO}}
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host control pins
  input wire logic tx_off,
  input wire logic receive_rate_select,
  input wire logic transmit_rate_select,
  input wire logic fc_mode,
  // Optical front end
  input wire logic rx_signal_detect,
  input wire logic laser_fault_detect,
  input wire omc_mon_s mon_raw,
  // Management bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Module outputs
  output logic laser_enable,
  output logic tx_fault,
  output logic rx_los,
  output logic high_power_en,
  output logic module_ready,
  output logic mgmt_ready,
  output logic rate_sel,
  output logic rate_stable
);
  typedef enum logic [1:0] {ST_SETTLE, ST_OPER, ST_FAULT, ST_WAIT_ON} omc_st_e;

  logic rst_a_r, rst_n;
  logic [OMC_NPIN-1:0] s1_r, s2_r, s3_r, pin_r;
  omc_st_e st_r;
  logic [OMC_CNT_W-1:0] settle_r, mgmt_cnt_r, rate_cnt_r;
  logic [OMC_HOLD_W-1:0] hold_r;
  logic fault_r, fault_clr, laser_r, los_r, hp_r, ready_r, mready_r, rate_r, rstab_r;
  logic sda_r, sl_oe, sl_hp, sl_stop;
  logic [OMC_CNT_W-1:0] op_cyc;
  omc_mon_s mon_cal_r;
  omc_stat_s stat;

  function automatic logic [15:0] calib(input logic [15:0] raw, slope, offs);
    logic [31:0] prod;
    prod = raw * slope;
    return 16'(prod >> OMC_SLOPE_FRAC) + offs;
  endfunction

  assign op_cyc = COOLED ? OMC_CNT_W'(START_COOLED_CYC) : OMC_CNT_W'(START_CYC);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n <= rst_a_r;
    end
  end

  // Three-stage capture; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= OMC_PIN_IDLE;
      s2_r <= OMC_PIN_IDLE;
      s3_r <= OMC_PIN_IDLE;
      pin_r <= OMC_PIN_IDLE;
    end else begin
      s1_r <= {sda_in, scl, laser_fault_detect, rx_signal_detect, receive_rate_select, tx_off};
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
    end
  end

  // Fault clear needs transmit-off high for the full hold; saturating count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= '0;
    end else if (!pin_r[OMC_P_TXOFF]) begin
      hold_r <= '0;
    end else if (hold_r != OMC_HOLD_W'(OMC_FAULT_CLR_CYC)) begin
      hold_r <= hold_r + 1'b1;
    end
  end

  assign fault_clr = pin_r[OMC_P_TXOFF] && hold_r == OMC_HOLD_W'(OMC_FAULT_CLR_CYC);

  // New fault wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
    end else if (pin_r[OMC_P_FAULT]) begin
      fault_r <= 1'b1;
    end else if (fault_clr) begin
      fault_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_SETTLE;
      settle_r <= '0;
    end else begin
      case (st_r)
        ST_SETTLE: begin
          if (pin_r[OMC_P_FAULT]) begin
            st_r <= ST_FAULT;
          end else if (settle_r >= op_cyc) begin
            st_r <= ST_OPER;
          end else begin
            settle_r <= settle_r + 1'b1;
          end
        end
        ST_OPER: begin
          if (pin_r[OMC_P_FAULT]) begin
            st_r <= ST_FAULT;
          end else if (sl_stop && sl_hp && !hp_r) begin
            // Higher power entry re-enters settle for HP_ENTRY_CYC, or a full restart when cooled
            st_r <= ST_SETTLE;
            settle_r <= COOLED ? '0 : op_cyc - OMC_CNT_W'(HP_ENTRY_CYC);
          end
        end
        ST_FAULT: begin
          if (!fault_r) st_r <= ST_WAIT_ON;
        end
        ST_WAIT_ON: begin
          if (pin_r[OMC_P_FAULT]) begin
            st_r <= ST_FAULT;
          end else if (!pin_r[OMC_P_TXOFF]) begin
            st_r <= ST_SETTLE;
            settle_r <= '0;
          end
        end
        default: st_r <= ST_SETTLE;
      endcase
    end
  end

  // Laser follows the synchronised pin directly, so off and on take a few cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      laser_r <= 1'b0;
    end else begin
      laser_r <= st_r == ST_OPER && !pin_r[OMC_P_TXOFF] && !fault_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= st_r == ST_OPER;
    end
  end

  // Power level drops and rises at the stop condition; a rise in operation also restarts settle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hp_r <= 1'b0;
    end else if (sl_stop) begin
      hp_r <= sl_hp;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_cnt_r <= '0;
      mready_r <= 1'b0;
    end else if (mgmt_cnt_r >= OMC_CNT_W'(MGMT_INIT_CYC)) begin
      mready_r <= 1'b1;
    end else begin
      mgmt_cnt_r <= mgmt_cnt_r + 1'b1;
    end
  end

  // Only the receive select is watched; the transmit select has no effect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_r <= 1'b0;
      rate_cnt_r <= '0;
      rstab_r <= 1'b1;
    end else if (pin_r[OMC_P_RATE] != rate_r) begin
      rate_r <= pin_r[OMC_P_RATE];
      rate_cnt_r <= fc_mode ? OMC_CNT_W'(RATE_FC_CYC) : OMC_CNT_W'(RATE_CYC);
      rstab_r <= 1'b0;
    end else if (rate_cnt_r != '0) begin
      rate_cnt_r <= rate_cnt_r - 1'b1;
    end else begin
      rstab_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      los_r <= 1'b1;
    end else begin
      los_r <= ~pin_r[OMC_P_SIGDET];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_cal_r <= '0;
    end else begin
      mon_cal_r.temp <= calib(mon_raw.temp, CAL_SLOPE.temp, CAL_OFFS.temp);
      mon_cal_r.vcc <= calib(mon_raw.vcc, CAL_SLOPE.vcc, CAL_OFFS.vcc);
      mon_cal_r.bias <= calib(mon_raw.bias, CAL_SLOPE.bias, CAL_OFFS.bias);
      mon_cal_r.tx_pwr <= calib(mon_raw.tx_pwr, CAL_SLOPE.tx_pwr, CAL_OFFS.tx_pwr);
      mon_cal_r.rx_pwr <= calib(mon_raw.rx_pwr, CAL_SLOPE.rx_pwr, CAL_OFFS.rx_pwr);
    end
  end

  // Open-drain bus: only the enable ever changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_r <= 1'b0;
    end else begin
      sda_r <= 1'b0;
    end
  end

  assign stat = '{ready: ready_r, tx_fault: fault_r, rx_los: los_r, laser_on: laser_r,
                  high_power: hp_r, rate_stable: rstab_r, rate: rate_r, cooled: COOLED};

  omc_mgmt_slave #(.DEV_ADDR(DEV_ADDR)) u_mgmt (
    .clk(clk),
    .rst_n(rst_n),
    .scl(pin_r[OMC_P_SCL]),
    .sda(pin_r[OMC_P_SDA]),
    .bus_enable(mready_r),
    .mon_cal(mon_cal_r),
    .mon_raw(mon_raw),
    .status(stat),
    .sda_oe(sl_oe),
    .hp_req(sl_hp),
    .ctrl_stop(sl_stop)
  );

  assign sda_out = sda_r;
  assign sda_oe = sl_oe;
  assign laser_enable = laser_r;
  assign tx_fault = fault_r;
  assign rx_los = los_r;
  assign high_power_en = hp_r;
  assign module_ready = ready_r;
  assign mgmt_ready = mready_r;
  assign rate_sel = rate_r;
  assign rate_stable = rstab_r;
endmodule

// File: omc_ctrl_monitor.sv
// Assertion checker for the optical module control block
module omc_ctrl_monitor import omc_pkg::*; #(
  parameter longint unsigned MGMT_INIT_CYC = OMC_MGMT_INIT_CYC,
  parameter longint unsigned START_CYC = OMC_START_CYC,
  parameter longint unsigned RATE_FC_CYC = OMC_RATE_FC_CYC,
  parameter longint unsigned RATE_CYC = OMC_RATE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host pins
  input wire logic tx_off,
  input wire logic receive_rate_select,
  input wire logic fc_mode,
  input wire logic rx_signal_detect,
  input wire logic laser_fault_detect,
  // Module outputs
  input wire logic laser_enable,
  input wire logic tx_fault,
  input wire logic rx_los,
  input wire logic module_ready,
  input wire logic mgmt_ready,
  input wire logic rate_sel,
  input wire logic rate_stable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Margins cover the three-stage pin filter and the reset synchroniser
  localparam longint MGMT_MAX = MGMT_INIT_CYC + 8;
  localparam longint READY_MAX = START_CYC + 12;
  localparam longint FC_MAX = RATE_FC_CYC + 8;
  localparam longint SLOW_MAX = RATE_CYC + 8;
  logic [39:0] up_cnt, wait_cnt, low_cnt;
  logic [15:0] hi_cnt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) up_cnt <= '0;
    else if (up_cnt != '1) up_cnt <= up_cnt + 40'h1;
  end
  // Only waits that no pin or fault holds back are bounded
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) wait_cnt <= '0;
    else if (module_ready || tx_off || tx_fault || laser_fault_detect) wait_cnt <= '0;
    else wait_cnt <= wait_cnt + 40'h1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_cnt <= '0;
    else if (rate_stable) low_cnt <= '0;
    else low_cnt <= low_cnt + 40'h1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hi_cnt <= '0;
    else if (!tx_off) hi_cnt <= '0;
    else if (hi_cnt != '1) hi_cnt <= hi_cnt + 16'h1;
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence off_held;
    tx_off [*8];
  endsequence
  sequence quiet_fault;
    (!tx_off) [*8] ##0 tx_fault;
  endsequence

  laser_off_a: assert property ($rose(tx_off) |-> ##[1:8] !laser_enable)
    else $error("laser still on after transmit-off rose");
  laser_hold_a: assert property (off_held |-> !laser_enable)
    else $error("laser on while transmit-off held");
  fault_flag_a: assert property ($rose(laser_fault_detect) |-> ##[1:8] tx_fault)
    else $error("fault output late");
  fault_latch_a: assert property (quiet_fault |=> tx_fault)
    else $error("fault output dropped without clear pulse");
  fault_clear_a: assert property ($fell(tx_fault) |-> hi_cnt >= OMC_FAULT_CLR_CYC)
    else $error("fault cleared by short transmit-off pulse");
  los_on_a: assert property ($fell(rx_signal_detect) |-> ##[1:8] rx_los)
    else $error("loss output late to assert");
  los_off_a: assert property ($rose(rx_signal_detect) |-> ##[1:8] !rx_los)
    else $error("loss output late to negate");
  settle_time_a: assert property (!rate_stable |-> low_cnt <= (fc_mode ? FC_MAX : SLOW_MAX))
    else $error("rate settle too long");
  rate_track_a: assert property ($changed(rate_sel) |-> rate_sel == receive_rate_select)
    else $error("rate select moved without receive pin");
  ready_time_a: assert property (wait_cnt <= READY_MAX)
    else $error("module not ready in time");
  mgmt_init_a: assert property ($rose(mgmt_ready) |-> up_cnt <= MGMT_MAX)
    else $error("management bus ready late");
endmodule

bind omc_ctrl omc_ctrl_monitor #(.MGMT_INIT_CYC(MGMT_INIT_CYC), .START_CYC(START_CYC),
  .RATE_FC_CYC(RATE_FC_CYC), .RATE_CYC(RATE_CYC)) u_mon (.clk(clk), .resetn(resetn),
  .tx_off(tx_off), .receive_rate_select(receive_rate_select), .fc_mode(fc_mode),
  .rx_signal_detect(rx_signal_detect), .laser_fault_detect(laser_fault_detect),
  .laser_enable(laser_enable), .tx_fault(tx_fault), .rx_los(rx_los),
  .module_ready(module_ready), .mgmt_ready(mgmt_ready), .rate_sel(rate_sel),
  .rate_stable(rate_stable));

// File: omc_ctrl_tb.sv
// Self-checking testbench for the optical module control block
module omc_ctrl_tb import omc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint unsigned T_MGMT = 400, T_START = 600, T_HP = 300, T_FC = 40, T_SLOW = 80;
  localparam int O_LAS = 7, O_FLT = 6, O_LOS = 5, O_HP = 4, O_RDY = 3, O_RST = 0;
  logic clk, resetn, tx_off, receive_rate_select, transmit_rate_select, fc_mode;
  logic rx_signal_detect, laser_fault_detect, scl, host_oe, sda_oe, sda_out;
  logic laser_enable, tx_fault, rx_los, high_power_en, module_ready, mgmt_ready;
  logic rate_sel, rate_stable, cool_ready;
  omc_mon_s mon_raw;
  int err_total = 0, num_checks = 0;
  longint cyc = 0, t0 = 0;
  wire logic sda = !(host_oe || sda_oe);
  wire logic [7:0] outs = {laser_enable, tx_fault, rx_los, high_power_en, module_ready,
    mgmt_ready, rate_sel, rate_stable};

  omc_ctrl #(.MGMT_INIT_CYC(T_MGMT), .START_CYC(T_START), .START_COOLED_CYC(T_START),
    .HP_ENTRY_CYC(T_HP), .RATE_FC_CYC(T_FC), .RATE_CYC(T_SLOW)) dut (.clk(clk),
    .resetn(resetn), .tx_off(tx_off), .receive_rate_select(receive_rate_select),
    .transmit_rate_select(transmit_rate_select), .fc_mode(fc_mode),
    .rx_signal_detect(rx_signal_detect), .laser_fault_detect(laser_fault_detect),
    .mon_raw(mon_raw), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .laser_enable(laser_enable), .tx_fault(tx_fault), .rx_los(rx_los),
    .high_power_en(high_power_en), .module_ready(module_ready), .mgmt_ready(mgmt_ready),
    .rate_sel(rate_sel), .rate_stable(rate_stable));
  omc_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
  // Cooled variant: a long uncooled limit shows which start-up time it obeys
  omc_ctrl #(.COOLED(1'b1), .MGMT_INIT_CYC(T_MGMT), .START_CYC(T_START * 8),
    .START_COOLED_CYC(T_START), .HP_ENTRY_CYC(T_HP), .RATE_FC_CYC(T_FC),
    .RATE_CYC(T_SLOW)) dut_cool (.clk(clk), .resetn(resetn), .tx_off(tx_off),
    .receive_rate_select(receive_rate_select), .transmit_rate_select(transmit_rate_select),
    .fc_mode(fc_mode), .rx_signal_detect(rx_signal_detect),
    .laser_fault_detect(laser_fault_detect), .mon_raw(mon_raw), .scl(1'b1), .sda_in(1'b1),
    .sda_out(), .sda_oe(), .laser_enable(), .tx_fault(), .rx_los(), .high_power_en(),
    .module_ready(cool_ready), .mgmt_ready(), .rate_sel(), .rate_stable());

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      $display("unexpected at %0t: cycle limit %h reached %h", $time, cyc, cyc);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for one output, then judge it
  task automatic wait_bit(input int idx, input logic v, input longint lim);
    longint n;
    n = 0;
    while (outs[idx] !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk(outs[idx], v);
  endtask
  task automatic mg_write(input logic [7:0] ptr, input logic [7:0] d);
    logic a0, a1, a2;
    host.start();
    host.wbyte({OMC_DEV_ADDR, 1'b0}, a0);
    host.wbyte(ptr, a1);
    host.wbyte(d, a2);
    host.stop();
    chk({13'h0, a0, a1, a2}, 16'h0000);
  endtask
  task automatic mg_read(input logic [7:0] ptr, output logic [15:0] w);
    logic a0, a1, a2;
    host.start();
    host.wbyte({OMC_DEV_ADDR, 1'b0}, a0);
    host.wbyte(ptr, a1);
    host.start();
    host.wbyte({OMC_DEV_ADDR, 1'b1}, a2);
    host.rbyte(1'b0, w[15:8]);
    host.rbyte(1'b1, w[7:0]);
    host.stop();
    chk({13'h0, a0, a1, a2}, 16'h0000);
  endtask

  task automatic t_startup();
    logic nack;
    chk({rx_los, rate_stable, laser_enable, mgmt_ready}, 16'h000C);
    resetn = 1'b1;
    t0 = cyc;
    host.start();
    host.wbyte({OMC_DEV_ADDR, 1'b0}, nack);
    host.stop();
    chk(nack, 1'b1);
    wait_bit(2, 1'b1, T_MGMT);
    wait_bit(O_RDY, 1'b1, T_START + 20 - (cyc - t0));
    chk(cool_ready, 1'b1);
  endtask
  task automatic t_txoff();
    tx_off = 1'b1;
    wait_bit(O_LAS, 1'b0, 20);
    tick(30);
    chk(laser_enable, 1'b0);
    tx_off = 1'b0;
    wait_bit(O_LAS, 1'b1, T_START + 20);
  endtask
  task automatic t_los();
    rx_signal_detect = 1'b0;
    wait_bit(O_LOS, 1'b1, 20);
    rx_signal_detect = 1'b1;
    wait_bit(O_LOS, 1'b0, 20);
  endtask
  task automatic t_rate(input logic fc, input logic v, input longint lim);
    fc_mode = fc;
    receive_rate_select = v;
    wait_bit(O_RST, 1'b0, 12);
    chk(rate_sel, v);
    wait_bit(O_RST, 1'b1, lim);
  endtask
  task automatic t_txrate();
    transmit_rate_select = 1'b1;
    tick(40);
    chk({rate_sel, rate_stable}, 16'h0001);
    transmit_rate_select = 1'b0;
  endtask
  task automatic t_fault();
    laser_fault_detect = 1'b1;
    wait_bit(O_FLT, 1'b1, 20);
    laser_fault_detect = 1'b0;
    tick(100);
    chk(tx_fault, 1'b1);
    tx_off = 1'b1;
    tick(1000);
    tx_off = 1'b0;
    tick(20);
    chk(tx_fault, 1'b1);
    tx_off = 1'b1;
    tick(OMC_FAULT_CLR_CYC + 20);
    chk(tx_fault, 1'b0);
    tx_off = 1'b0;
    wait_bit(O_RDY, 1'b1, T_START + 20);
    chk(cool_ready, 1'b1);
    wait_bit(O_LAS, 1'b1, 20);
  endtask
  task automatic t_mgmt();
    logic [15:0] w;
    mg_write(OMC_CTRL_ADDR, 8'h01);
    wait_bit(O_HP, 1'b1, 10);
    chk(module_ready, 1'b0);
    wait_bit(O_RDY, 1'b1, T_HP + 20);
    mg_read(OMC_RAW_BASE, w);
    chk(w, 16'hA55A);
    mg_read(OMC_CAL_BASE, w);
    chk(w, 16'hA55A);
    mg_read(8'h50, w);
    chk(w, 16'h0000);
    chk(sda_out, 1'b0);
    mg_write(OMC_CTRL_ADDR, 8'h00);
    wait_bit(O_HP, 1'b0, 10);
  endtask

  initial begin
    resetn = 1'b0;
    tx_off = 1'b0;
    receive_rate_select = 1'b0;
    transmit_rate_select = 1'b0;
    fc_mode = 1'b0;
    rx_signal_detect = 1'b1;
    laser_fault_detect = 1'b0;
    mon_raw = {5{16'hA55A}};
    tick(6);
    t_startup();
    t_txoff();
    t_los();
    t_rate(1'b1, 1'b1, T_FC + 12);
    t_rate(1'b0, 1'b0, T_SLOW + 12);
    t_txrate();
    t_fault();
    t_mgmt();
    test_done();
  end
endmodule

// File: omc_host_model.sv
// Host-side model: controller of the two-wire management bus
module omc_host_model #(
  parameter int HALF = 10
) (
  // Clock
  input wire logic clk,
  // Wire level and host drive
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Phases span many clocks so the target's pin filters always settle
  task automatic half();
    repeat (HALF) @(posedge clk);
    #1;
  endtask
  task automatic start();
    sda_oe = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_oe = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_oe = 1'b0;
    half();
  endtask
  task automatic put_bit(input logic b);
    sda_oe = !b;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic get_bit(output logic b);
    sda_oe = 1'b0;
    half();
    scl = 1'b1;
    half();
    b = sda;
    scl = 1'b0;
    half();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(nack);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule

// File: omc_mgmt_slave.sv
// Two-wire management target: identification, monitors, status, power control
module omc_mgmt_slave import omc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = OMC_DEV_ADDR
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filtered bus levels
  input wire logic scl,
  input wire logic sda,
  input wire logic bus_enable,
  // Readable data
  input wire omc_mon_s mon_cal,
  input wire omc_mon_s mon_raw,
  input wire omc_stat_s status,
  // Bus drive and power control
  output logic sda_oe,
  output logic hp_req,
  output logic ctrl_stop
);
  typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_WR, SL_RD} omc_sl_e;
  // Arbitrary identification contents
  localparam logic [7:0] ID_ROM [8] = '{8'h03, 8'h04, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  omc_sl_e state_r;
  logic scl_q_r, sda_q_r, rw_r, first_r, dirty_r, nack_r, oe_r, hp_r, stop_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r, tx_r, ptr_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] rd_cur;

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] i;
    i = 8'h00;
    if (a < OMC_ID_LEN) return ID_ROM[a[2:0]];
    if (a >= OMC_CAL_BASE && a < OMC_CAL_BASE + OMC_MON_BYTES) begin
      i = a - OMC_CAL_BASE;
      return mon_cal[79 - 8 * i -: 8];
    end
    if (a >= OMC_RAW_BASE && a < OMC_RAW_BASE + OMC_MON_BYTES) begin
      i = a - OMC_RAW_BASE;
      return mon_raw[79 - 8 * i -: 8];
    end
    if (a == OMC_STAT_ADDR) return status;
    if (a == OMC_CTRL_ADDR) return {7'h00, hp_r};
    return 8'h00;
  endfunction

  // Byte at the pointer; held in a signal so its top bit can be picked
  always_comb begin
    rd_cur = rd_byte(ptr_r);
  end

  assign scl_rise = scl & ~scl_q_r;
  assign scl_fall = ~scl & scl_q_r;
  assign start_c = scl & scl_q_r & sda_q_r & ~sda;
  assign stop_c = scl & scl_q_r & ~sda_q_r & sda;
  assign sda_oe = oe_r;
  assign hp_req = hp_r;
  assign ctrl_stop = stop_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SL_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      dirty_r <= 1'b0;
      nack_r <= 1'b0;
      oe_r <= 1'b0;
      hp_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      stop_r <= 1'b0;
      if (stop_c) begin
        // Power change takes effect at the stop condition, not the data byte
        stop_r <= dirty_r;
        dirty_r <= 1'b0;
        state_r <= SL_IDLE;
        oe_r <= 1'b0;
      end else if (start_c) begin
        state_r <= SL_ADDR;
        bit_r <= 4'h0;
        oe_r <= 1'b0;
      end else if (state_r != SL_IDLE && scl_rise) begin
        if (bit_r < 4'h8) sh_r <= {sh_r[6:0], sda};
        if (bit_r == 4'h8) nack_r <= sda;
        bit_r <= bit_r + 4'h1;
      end else if (state_r != SL_IDLE && scl_fall) begin
        if (bit_r == 4'h8) begin
          case (state_r)
            SL_ADDR: begin
              // No answer until the bus has finished its start-up
              if (sh_r[7:1] == DEV_ADDR && bus_enable) begin
                oe_r <= 1'b1;
                rw_r <= sh_r[0];
                first_r <= 1'b1;
              end else begin
                state_r <= SL_IDLE;
              end
            end
            SL_WR: begin
              oe_r <= 1'b1;
              first_r <= 1'b0;
              if (first_r) begin
                ptr_r <= sh_r;
              end else begin
                if (ptr_r == OMC_CTRL_ADDR) begin
                  hp_r <= sh_r[OMC_CTRL_HP_BIT];
                  dirty_r <= 1'b1;
                end
                ptr_r <= ptr_r + 8'h01;
              end
            end
            SL_RD: oe_r <= 1'b0;
            default: state_r <= SL_IDLE;
          endcase
        end else if (bit_r == 4'h9) begin
          bit_r <= 4'h0;
          oe_r <= 1'b0;
          if ((state_r == SL_ADDR && rw_r) || (state_r == SL_RD && !nack_r)) begin
            // Identification and monitor bytes leave MSB first
            state_r <= SL_RD;
            tx_r <= rd_cur;
            oe_r <= ~rd_cur[7];
            ptr_r <= ptr_r + 8'h01;
          end else if (state_r == SL_ADDR) begin
            state_r <= SL_WR;
          end else if (state_r == SL_RD) begin
            state_r <= SL_IDLE;
          end
        end else if (state_r == SL_RD) begin
          oe_r <= ~tx_r[3'h7 - bit_r[2:0]];
        end
      end
    end
  end
endmodule

// File: omc_pkg.sv
// Shared constants and types for the optical module control block
package omc_pkg;
  // Clock period and printed time limits
  localparam longint unsigned OMC_CLK_NS = 5;
  localparam longint unsigned OMC_NS_PER_US = 1000;
  localparam longint unsigned OMC_NS_PER_MS = 1000000;
  localparam longint unsigned OMC_NS_PER_S = 1000000000;
  localparam longint unsigned OMC_T_OFF_US = 100;
  localparam longint unsigned OMC_T_ON_MS = 2;
  localparam longint unsigned OMC_T_MGMT_INIT_MS = 300;
  localparam longint unsigned OMC_T_START_MS = 300;
  localparam longint unsigned OMC_T_START_COOLED_S = 90;
  localparam longint unsigned OMC_T_HIGH_POWER_ENTRY_MS = 300;
  localparam longint unsigned OMC_T_POWER_DOWN_MS = 300;
  localparam longint unsigned OMC_T_FAULT_ON_MS = 1;
  localparam longint unsigned OMC_T_FAULT_ON_COOLED_MS = 50;
  localparam longint unsigned OMC_T_FAULT_CLR_US = 10;
  localparam longint unsigned OMC_T_RATE_FC_US = 500;
  localparam longint unsigned OMC_T_RATE_MS = 24;
  localparam longint unsigned OMC_T_LOS_US = 100;
  // Cycle counts: longest times round down, least times round up
  localparam longint unsigned OMC_MGMT_INIT_CYC = OMC_T_MGMT_INIT_MS * OMC_NS_PER_MS / OMC_CLK_NS;
  localparam longint unsigned OMC_START_CYC = OMC_T_START_MS * OMC_NS_PER_MS / OMC_CLK_NS;
  localparam longint unsigned OMC_START_COOLED_CYC =
    OMC_T_START_COOLED_S * OMC_NS_PER_S / OMC_CLK_NS;
  localparam longint unsigned OMC_HP_ENTRY_CYC =
    OMC_T_HIGH_POWER_ENTRY_MS * OMC_NS_PER_MS / OMC_CLK_NS;
  localparam longint unsigned OMC_RATE_FC_CYC = OMC_T_RATE_FC_US * OMC_NS_PER_US / OMC_CLK_NS;
  localparam longint unsigned OMC_RATE_CYC = OMC_T_RATE_MS * OMC_NS_PER_MS / OMC_CLK_NS;
  localparam int unsigned OMC_FAULT_CLR_CYC =
    int'((OMC_T_FAULT_CLR_US * OMC_NS_PER_US + OMC_CLK_NS - 1) / OMC_CLK_NS);
  localparam int OMC_CNT_W = 36;
  localparam int OMC_HOLD_W = 12;
  // Pin vector positions and idle levels
  localparam int OMC_P_TXOFF = 0;
  localparam int OMC_P_RATE = 1;
  localparam int OMC_P_SIGDET = 2;
  localparam int OMC_P_FAULT = 3;
  localparam int OMC_P_SCL = 4;
  localparam int OMC_P_SDA = 5;
  localparam int OMC_NPIN = 6;
  localparam logic [5:0] OMC_PIN_IDLE = 6'h30;
  // Management byte map
  localparam logic [7:0] OMC_ID_LEN = 8'h08;
  localparam logic [7:0] OMC_CAL_BASE = 8'h10;
  localparam logic [7:0] OMC_RAW_BASE = 8'h20;
  localparam logic [7:0] OMC_MON_BYTES = 8'h0A;
  localparam logic [7:0] OMC_STAT_ADDR = 8'h30;
  localparam logic [7:0] OMC_CTRL_ADDR = 8'h40;
  localparam int OMC_CTRL_HP_BIT = 0;
  localparam logic [6:0] OMC_DEV_ADDR = 7'h50;
  // Calibration defaults: slope is 8.8 fixed point
  localparam logic [15:0] OMC_SLOPE_ONE = 16'h0100;
  localparam logic [15:0] OMC_OFFS_ZERO = 16'h0000;
  localparam int OMC_SLOPE_FRAC = 8;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] tx_pwr;
    logic [15:0] rx_pwr;
  } omc_mon_s;

  typedef struct packed {
    logic ready;
    logic tx_fault;
    logic rx_los;
    logic laser_on;
    logic high_power;
    logic rate_stable;
    logic rate;
    logic cooled;
  } omc_stat_s;
endpackage
